/* File: verilog/vmx_pkg.sv */
// Shared constants, field layouts and state types for the video matrix write port.
// Assumes a 200 MHz system clock and a two-wire master clocking at a nominal 100 kHz.
package vmx_pkg;

  // Clock and serial timing figures.
  localparam int CLK_MHZ = 200;
  localparam int SCL_NOMINAL_KHZ = 100;
  localparam int POWER_TIME_NS = 300;
  localparam int POWER_CYCLES = POWER_TIME_NS * CLK_MHZ / 1000;
  localparam logic [5:0] PWR_CNT_LAST = 6'(POWER_CYCLES - 1);

  // Matrix dimensions.
  localparam int NUM_OUT = 9;
  localparam int NUM_IN = 12;

  // Bus address bytes (write direction), picked by the strap pin.
  localparam logic [7:0] DEV_ADDR_LO = 8'h06;
  localparam logic [7:0] DEV_ADDR_HI = 8'h86;

  // Internal register addresses.
  localparam logic [7:0] REG_OUT_FIRST = 8'h01;
  localparam logic [7:0] REG_COUPLE_LO = 8'h1d;
  localparam logic [7:0] REG_COUPLE_HI = 8'h1e;

  // Source codes and byte framing.
  localparam logic [4:0] SRC_NONE = 5'h00;
  localparam logic [4:0] SRC_LAST = 5'h0c;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Values after reset.
  localparam logic ENABLE_RST = 1'b1;
  localparam logic [1:0] GAIN_RST = 2'h0;
  localparam logic [4:0] SRC_RST = 5'h00;
  localparam logic [11:0] COUPLE_RST = 12'h000;

  // One output control byte: enable in bit 7, gain in 6:5, source in 4:0.
  typedef struct packed {
    logic enable;
    logic [1:0] gain;
    logic [4:0] source;
  } vmx_route_t;

  typedef enum logic [1:0] {ST_IDLE, ST_RX, ST_ACK, ST_SKIP} vmx_fsm_t;
  typedef enum logic [1:0] {PH_ADDR, PH_REG, PH_DATA} vmx_phase_t;

  // Pins that cross into the clock domain.
  typedef struct packed {
    logic scl;
    logic sda;
    logic strap;
  } vmx_pins_t;

  typedef struct packed {
    vmx_pins_t s1;
    vmx_pins_t s2;
  } vmx_sync_t;

  // Whole state of the port.
  typedef struct packed {
    vmx_fsm_t fsm;
    vmx_phase_t phase;
    logic sclPrev;
    logic sdaPrev;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic sdaOe;
    logic sdaOut;
    vmx_route_t [8:0] route;
    logic [11:0] couple;
    logic [8:0] powered;
    logic [8:0][5:0] pwrCnt;
    logic [8:0] ampForced;
  } vmx_state_t;

endpackage : vmx_pkg

/* File: verilog/vmx_sync.sv */
// Two-stage synchroniser for the serial clock, serial data and address strap pins.
// Assumes the pins are asynchronous to clk; only the second stage is read outside.
`timescale 1ns/10ps
module vmx_sync (
  input wire logic clk, // System clock.
  input wire logic sys_rst, // Asynchronous reset, active high.
  input wire vmx_pkg::vmx_pins_t pinsIn, // Raw pin levels.
  output vmx_pkg::vmx_pins_t pinsOut // Synchronised pin levels.
);

  vmx_pkg::vmx_sync_t st;
  vmx_pkg::vmx_sync_t next_st;

  // The first stage feeds only the second, so metastability has a full cycle to settle.
  always_comb begin
    next_st.s1 = pinsIn;
    next_st.s2 = st.s1;
  end

  // Idle bus lines are high, so reset to high to avoid a false start at release.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= {3'h7, 3'h7};
    end else begin
      st <= next_st;
    end
  end

  assign pinsOut = st.s2;

endmodule : vmx_sync

/* File: verilog/vmx_i2c_port.sv */
// Write-only two-wire slave port and control registers for a 12-by-9 video crosspoint.
// Assumes an external master drives the serial clock; all pins are asynchronous to clk.
//
// Contract
// - Standard Mode slave, master clocks 100 kHz.
// - Writes only; nothing is ever read back.
// - Both lines high means bus idle.
// - One bit per clock, sampled clock high.
// - Data moving during clock high is control.
// - Data falling, clock high: start, reframe.
// - Data rising, clock high: stop, idle.
// - No limit on bytes per transfer.
// - Eight data bits plus acknowledge slot.
// - Acknowledge every byte when addressed.
// - Hold data low across acknowledge clock high.
// - First byte after start is the address.
// - Second byte loads pointer; data goes there.
// - Per-input clamp or bias from written bits.
// - Cleared enable powers output down, high impedance.
// - Power state follows enable within 300 ns.
// - Output stays active unless enable cleared.
// - Source none forces amplifier input level.
// - Strap pin picks low or high address.
// - Output byte: enable, gain, source fields.
// - Clamp bytes one bit per input, reset 0.
// - Undefined addresses acknowledged, change nothing.
`timescale 1ns/10ps
module vmx_i2c_port (
  input wire logic clk, // System clock, 200 MHz.
  input wire logic sys_rst, // Asynchronous reset, active high.
  input wire logic sclIn, // Serial clock pin level.
  input wire logic sdaIn, // Serial data pin level.
  output logic sdaOut, // Serial data drive level, always low.
  output logic sdaOe, // High while the port pulls data low.
  input wire logic addrStrap, // Address strap pin.
  output vmx_pkg::vmx_route_t [8:0] routeCtl, // Per-output enable, gain and source.
  output logic [8:0] ampActive, // Per-output amplifier powered state.
  output logic [8:0] ampForced, // Per-output amplifier input tied to fixed level.
  output logic [11:0] inputClamp // Per-input coupling: 1 clamp, 0 bias.
);

  vmx_pkg::vmx_state_t st;
  vmx_pkg::vmx_state_t next_st;
  vmx_pkg::vmx_pins_t pinsRaw;
  vmx_pkg::vmx_pins_t pins;
  logic sclRise;
  logic sclFall;
  logic startDet;
  logic stopDet;
  logic wrStrobe;
  logic addrMatch;

  // True when a source code selects no existing input.
  function automatic logic src_is_none(input logic [4:0] src);
    src_is_none = (src == vmx_pkg::SRC_NONE) || (src > vmx_pkg::SRC_LAST);
  endfunction : src_is_none

  // Pins cross into the clock domain before anything looks at them.
  // At 200 MHz each level of a 100 kHz serial clock lasts a thousand cycles, so two stages cost nothing.
  assign pinsRaw = '{scl: sclIn, sda: sdaIn, strap: addrStrap};

  vmx_sync u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pinsIn(pinsRaw),
    .pinsOut(pins)
  );

  // Line events from the synchronised levels; data is sampled at the clock rise.
  assign sclRise = pins.scl & ~st.sclPrev;
  assign sclFall = ~pins.scl & st.sclPrev;
  assign startDet = pins.scl & st.sclPrev & st.sdaPrev & ~pins.sda;
  assign stopDet = pins.scl & st.sclPrev & ~st.sdaPrev & pins.sda;

  // Address byte must match the strapped value including a write direction bit.
  assign addrMatch = (st.shift == (pins.strap ? vmx_pkg::DEV_ADDR_HI : vmx_pkg::DEV_ADDR_LO));

  // Next-state logic: framing, acknowledge, register writes and power timers.
  always_comb begin
    next_st = st;
    wrStrobe = 1'b0;
    next_st.sclPrev = pins.scl;
    next_st.sdaPrev = pins.sda;
    if (startDet) begin
      next_st.fsm = vmx_pkg::ST_RX;
      next_st.phase = vmx_pkg::PH_ADDR;
      next_st.bitCnt = 4'h0;
      next_st.sdaOe = 1'b0;
    end else if (stopDet) begin
      next_st.fsm = vmx_pkg::ST_IDLE;
      next_st.bitCnt = 4'h0;
      next_st.sdaOe = 1'b0;
    end else begin
      case (st.fsm)
        vmx_pkg::ST_IDLE: begin
          // Waits with the data line released for the next start.
          next_st.sdaOe = 1'b0;
        end
        vmx_pkg::ST_RX: begin
          if (sclRise && (st.bitCnt < vmx_pkg::BITS_PER_BYTE)) begin
            next_st.shift = {st.shift[6:0], pins.sda};
            next_st.bitCnt = st.bitCnt + 4'h1;
          end else if (sclFall && (st.bitCnt == vmx_pkg::BITS_PER_BYTE)) begin
            // Eight bits in: decide, and unless the address is foreign pull data low before the ninth clock rises.
            case (st.phase)
              vmx_pkg::PH_ADDR: begin
                if (addrMatch) begin
                  next_st.sdaOe = 1'b1;
                  next_st.fsm = vmx_pkg::ST_ACK;
                  next_st.phase = vmx_pkg::PH_REG;
                end else begin
                  next_st.fsm = vmx_pkg::ST_SKIP;
                end
              end
              vmx_pkg::PH_REG: begin
                next_st.ptr = st.shift;
                next_st.sdaOe = 1'b1;
                next_st.fsm = vmx_pkg::ST_ACK;
                next_st.phase = vmx_pkg::PH_DATA;
              end
              default: begin
                wrStrobe = 1'b1;
                // Every data byte is acknowledged, defined address or not.
                for (int i = 0; i < vmx_pkg::NUM_OUT; i++) begin
                  if (st.ptr == vmx_pkg::REG_OUT_FIRST + 8'(i)) begin
                    next_st.route[i] = st.shift;
                  end
                end
                if (st.ptr == vmx_pkg::REG_COUPLE_LO) begin
                  next_st.couple[7:0] = st.shift;
                end
                if (st.ptr == vmx_pkg::REG_COUPLE_HI) begin
                  next_st.couple[11:8] = st.shift[3:0];
                end
                next_st.ptr = st.ptr + 8'h01;
                next_st.sdaOe = 1'b1;
                next_st.fsm = vmx_pkg::ST_ACK;
              end
            endcase
          end
        end
        vmx_pkg::ST_ACK: begin
          // Release after the acknowledge clock falls; zero hold time is enough.
          if (sclFall) begin
            next_st.sdaOe = 1'b0;
            next_st.fsm = vmx_pkg::ST_RX;
            next_st.bitCnt = 4'h0;
          end
        end
        vmx_pkg::ST_SKIP: begin
          next_st.sdaOe = 1'b0;
        end
        default: begin
          next_st.fsm = vmx_pkg::ST_IDLE;
          next_st.sdaOe = 1'b0;
        end
      endcase
    end
    // Power state trails the enable bit by a fixed settling count.
    for (int i = 0; i < vmx_pkg::NUM_OUT; i++) begin
      if (st.route[i].enable != st.powered[i]) begin
        if (st.pwrCnt[i] == vmx_pkg::PWR_CNT_LAST) begin
          next_st.powered[i] = st.route[i].enable;
          next_st.pwrCnt[i] = 6'h00;
        end else begin
          next_st.pwrCnt[i] = st.pwrCnt[i] + 6'h01;
        end
      end else begin
        next_st.pwrCnt[i] = 6'h00;
      end
      next_st.ampForced[i] = src_is_none(next_st.route[i].source);
    end
  end

  // State register; outputs start enabled so no output goes dark before a write.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st.fsm <= vmx_pkg::ST_IDLE;
      st.phase <= vmx_pkg::PH_ADDR;
      st.sclPrev <= 1'b1;
      st.sdaPrev <= 1'b1;
      st.bitCnt <= 4'h0;
      st.shift <= 8'h00;
      st.ptr <= 8'h00;
      st.sdaOe <= 1'b0;
      st.sdaOut <= 1'b0;
      st.route <= {vmx_pkg::NUM_OUT{vmx_pkg::ENABLE_RST, vmx_pkg::GAIN_RST, vmx_pkg::SRC_RST}};
      st.couple <= vmx_pkg::COUPLE_RST;
      st.powered <= {vmx_pkg::NUM_OUT{vmx_pkg::ENABLE_RST}};
      st.pwrCnt <= '0;
      st.ampForced <= 9'h1ff;
    end else begin
      st <= next_st;
    end
  end

  // Every output comes straight from the state register.
  assign sdaOut = st.sdaOut;
  assign sdaOe = st.sdaOe;
  assign routeCtl = st.route;
  assign ampActive = st.powered;
  assign ampForced = st.ampForced;
  assign inputClamp = st.couple;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // Idle and ignoring states never pull the data line.
  a_idle_released: assert property ((st.fsm == vmx_pkg::ST_IDLE) || (st.fsm == vmx_pkg::ST_SKIP) |-> !sdaOe)
    else $error("Data line driven while idle or ignoring.");

  // A stop returns the port to idle with data released.
  a_stop_to_idle: assert property (stopDet |=> (st.fsm == vmx_pkg::ST_IDLE) && !sdaOe)
    else $error("Stop did not return port to idle.");

  // A start reframes on the address byte.
  a_start_reframe: assert property (startDet |=> (st.fsm == vmx_pkg::ST_RX) && (st.bitCnt == 4'h0)
      && (st.phase == vmx_pkg::PH_ADDR))
    else $error("Start did not reset byte framing.");

  // The acknowledge holds while the clock is high.
  a_ack_held: assert property (sdaOe && pins.scl && st.sclPrev && !startDet && !stopDet |=> sdaOe)
    else $error("Acknowledge released during clock high.");

  // The bit counter never exceeds one byte.
  a_byte_length: assert property (st.bitCnt <= vmx_pkg::BITS_PER_BYTE)
    else $error("Bit counter ran past eight.");

  // A data byte completed in a frame is acknowledged on the following cycle.
  a_data_acked: assert property (wrStrobe |=> sdaOe && (st.fsm == vmx_pkg::ST_ACK))
    else $error("Data byte was not acknowledged.");

  // The pointer advances by one after every stored byte.
  a_ptr_advance: assert property (wrStrobe |=> st.ptr == $past(st.ptr) + 8'h01)
    else $error("Register pointer did not advance.");

  // Writes to undefined addresses leave all control state unchanged.
  a_undef_quiet: assert property (wrStrobe && ((st.ptr < vmx_pkg::REG_OUT_FIRST)
      || ((st.ptr >= vmx_pkg::REG_OUT_FIRST + 8'(vmx_pkg::NUM_OUT)) && (st.ptr != vmx_pkg::REG_COUPLE_LO)
      && (st.ptr != vmx_pkg::REG_COUPLE_HI))) |=> $stable(st.route) && $stable(st.couple))
    else $error("Undefined address write changed state.");

  // The upper clamp bits change only through their own register; its reserved bits are dropped.
  a_clamp_reserved: assert property (!$stable(st.couple[11:8]) |-> $past(wrStrobe)
      && ($past(st.ptr) == vmx_pkg::REG_COUPLE_HI))
    else $error("Upper clamp bits changed without their write.");

  // Eight bits have arrived and the acknowledge decision falls due on this cycle.
  logic byteDone;
  assign byteDone = (st.fsm == vmx_pkg::ST_RX) && sclFall && (st.bitCnt == vmx_pkg::BITS_PER_BYTE);

  // Each clock rise while framing takes exactly one bit, the latest one landing at the bottom.
  a_bit_shift: assert property (sclRise && (st.fsm == vmx_pkg::ST_RX)
      && (st.bitCnt < vmx_pkg::BITS_PER_BYTE) |=> (st.shift[0] == $past(pins.sda))
      && (st.bitCnt == $past(st.bitCnt) + 4'h1))
    else $error("Clock rise did not shift in exactly one bit.");

  // A matching write address is acknowledged and moves on to the pointer byte.
  a_addr_acked: assert property (byteDone && (st.phase == vmx_pkg::PH_ADDR) && addrMatch
      |=> sdaOe && (st.fsm == vmx_pkg::ST_ACK) && (st.phase == vmx_pkg::PH_REG))
    else $error("Matching address was not acknowledged.");

  // Any other address, a read included, leaves the line released until the next start.
  a_addr_refused: assert property (byteDone && (st.phase == vmx_pkg::PH_ADDR) && !addrMatch
      |=> !sdaOe && (st.fsm == vmx_pkg::ST_SKIP))
    else $error("Foreign or read address was not refused.");

  // The second byte loads the pointer whole and is acknowledged.
  a_ptr_load: assert property (byteDone && (st.phase == vmx_pkg::PH_REG)
      |=> sdaOe && (st.ptr == $past(st.shift)) && (st.phase == vmx_pkg::PH_DATA))
    else $error("Pointer byte was not loaded.");

  // The acknowledge is let go on the fall of its own clock and framing restarts at bit zero.
  a_ack_release: assert property ((st.fsm == vmx_pkg::ST_ACK) && sclFall
      |=> !sdaOe && (st.fsm == vmx_pkg::ST_RX) && (st.bitCnt == 4'h0))
    else $error("Acknowledge was not released after its clock.");

  // The data line is only ever pulled in an acknowledge slot; no bit is ever sent back.
  a_no_readback: assert property (sdaOe |-> (st.fsm == vmx_pkg::ST_ACK))
    else $error("Data line driven outside an acknowledge slot.");

  // The lower clamp bits change only through their own register.
  a_clamp_write: assert property (!$stable(st.couple[7:0]) |-> $past(wrStrobe)
      && ($past(st.ptr) == vmx_pkg::REG_COUPLE_LO))
    else $error("Lower clamp bits changed without their write.");

  // Output bytes change only through a write inside the output register range.
  a_route_write: assert property (!$stable(st.route) |-> $past(wrStrobe)
      && ($past(st.ptr) >= vmx_pkg::REG_OUT_FIRST)
      && ($past(st.ptr) < vmx_pkg::REG_OUT_FIRST + 8'(vmx_pkg::NUM_OUT)))
    else $error("Output byte changed without its write.");

  // Per-output power state follows its enable within the settling time.
  for (genvar g = 0; g < vmx_pkg::NUM_OUT; g++) begin : g_out_chk
    a_power_follow: assert property ((routeCtl[g].enable != ampActive[g])
        |-> ##[0:60] ((routeCtl[g].enable == ampActive[g]) || $changed(routeCtl[g].enable)))
      else $error("Output power state lagged its enable.");
    // Power only ever moves toward the enable bit that stood before the edge.
    a_power_source: assert property (!$stable(ampActive[g])
        |-> (ampActive[g] == $past(routeCtl[g].enable)))
      else $error("Output power state moved against its enable.");
    a_forced_level: assert property (ampForced[g] == src_is_none(routeCtl[g].source))
      else $error("Forced level disagrees with source code.");
  end

endmodule : vmx_i2c_port

/* File: tb/vmx_master.sv */
// Behavioural two-wire bus master for the video matrix write port.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/10ps
module vmx_master (
  output logic scl, // Serial clock, high outside frames.
  output logic sdaDrv, // Data drive: 0 pulls low, 1 releases.
  input wire logic sdaWire // Resolved data line.
);
  // Quarter of the 64 ns link period.
  localparam int Q = 16;

  // Idle bus: both lines high.
  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
  end

  // Data falls while the clock is high; works from idle or from a low clock.
  task automatic startCond();
    #(Q) sdaDrv = 1'b1;
    #(Q) scl = 1'b1;
    #(Q) sdaDrv = 1'b0;
    #(Q) scl = 1'b0;
  endtask : startCond

  // Data rises while the clock is high, then the clock stands still.
  task automatic stopCond();
    #(Q) sdaDrv = 1'b0;
    #(Q) scl = 1'b1;
    #(Q) sdaDrv = 1'b1;
    #(Q);
  endtask : stopCond

  // Data moves only while the clock is low, so the slave never sees a false start.
  task automatic sendBit(input logic v, output logic seen);
    #(Q) sdaDrv = v;
    #(Q) scl = 1'b1;
    #(Q) seen = sdaWire;
    #(Q) scl = 1'b0;
  endtask : sendBit

  // Eight bits MSB first, then a released ninth slot for the acknowledge.
  task automatic sendByte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      sendBit(b[i], s);
    end
    sendBit(1'b1, s);
    ack = ~s;
  endtask : sendByte
endmodule : vmx_master

/* File: tb/testbench.sv */
// Self-checking bench for the video matrix write port.
// Assumes vmx_master drives the serial pins and the data line has a pull-up.
`timescale 1ns/10ps
module testbench;
  localparam int LIMIT = 20000;
  logic clk = 1'b0;
  logic sysRst = 1'b1;
  logic addrStrap = 1'b0;
  logic scl, sdaDrv, sdaOut, sdaOe;
  wire sdaWire;
  vmx_pkg::vmx_route_t [8:0] routeCtl;
  vmx_pkg::vmx_route_t [8:0] expRoute;
  logic [8:0] ampActive, ampForced;
  logic [11:0] inputClamp;
  logic [7:0] dev = 8'h06;
  int err_total = 0;
  int checked = 0;
  int cycles = 0;

  // Either party may pull the line low; otherwise the pull-up wins.
  assign sdaWire = sdaDrv & ~(sdaOe & ~sdaOut);

  vmx_master vmx_master_i (.scl(scl), .sdaDrv(sdaDrv), .sdaWire(sdaWire));
  vmx_i2c_port vmx_i2c_port_i (.clk(clk), .sys_rst(sysRst), .sclIn(scl), .sdaIn(sdaWire),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .addrStrap(addrStrap), .routeCtl(routeCtl),
    .ampActive(ampActive), .ampForced(ampForced), .inputClamp(inputClamp));

  always #2.5 clk = ~clk;

  // A hung handshake would stall the run forever, so cap it.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      err_total++;
      end_sim();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim

  // One framed write; every byte must be acknowledged or every byte refused.
  task automatic xfer(input logic [7:0] q[$], input logic expAck);
    logic ack;
    vmx_master_i.startCond();
    foreach (q[i]) begin
      vmx_master_i.sendByte(q[i], ack);
      check(16'(ack), 16'(expAck));
    end
    vmx_master_i.stopCond();
  endtask : xfer

  task automatic bits(input int n);
    logic s;
    for (int i = 0; i < n; i++) begin
      vmx_master_i.sendBit(1'b1, s);
    end
  endtask : bits

  task automatic checkRoutes();
    for (int i = 0; i < 9; i++) begin
      check(16'(routeCtl[i]), 16'(expRoute[i]));
      check(16'(ampForced[i]), 16'(expRoute[i].source == 5'h00 || expRoute[i].source > 5'h0c));
    end
  endtask : checkRoutes

  task automatic tReset();
    for (int i = 0; i < 9; i++) begin
      expRoute[i] = 8'h80;
    end
    checkRoutes();
    check(16'(ampActive), 16'h01ff);
    check(16'(inputClamp), 16'h0000);
    check(16'(sdaOe), 16'h0000);
    check(16'(sdaOut), 16'h0000);
  endtask : tReset

  // All nine outputs in one burst, every gain code, a none source and an out-of-range source.
  task automatic tBurst();
    logic [7:0] d[$] = '{8'h01, 8'h2c, 8'hcd, 8'h6c, 8'h80, 8'h8c, 8'ha1, 8'hc7, 8'h60};
    logic [7:0] q[$];
    logic [8:0] en;
    q = '{dev, 8'h01};
    foreach (d[i]) begin
      q.push_back(d[i]);
      expRoute[i] = d[i];
      en[i] = d[i][7];
    end
    xfer(q, 1'b1);
    check(16'(ampActive[8]), 16'h0001);
    repeat (45) @(posedge clk);
    checkRoutes();
    check(16'(ampActive), 16'(en));
  endtask : tBurst

  // The pointer runs on into an undefined address, which must leave state alone.
  task automatic tClamp();
    xfer('{dev, 8'h1d, 8'ha5, 8'hf3, 8'h5a}, 1'b1);
    xfer('{dev, 8'h00, 8'hff}, 1'b1);
    xfer('{dev, 8'h0a, 8'hff}, 1'b1);
    xfer('{dev, 8'h03}, 1'b1);
    check(16'(inputClamp), 16'h03a5);
    checkRoutes();
  endtask : tClamp

  // A stop in mid-byte discards it; a start in mid-byte reframes.
  task automatic tAbort();
    logic a;
    vmx_master_i.startCond();
    vmx_master_i.sendByte(dev, a);
    vmx_master_i.sendByte(8'h02, a);
    bits(5);
    vmx_master_i.stopCond();
    check(16'(routeCtl[1]), 16'(expRoute[1]));
    vmx_master_i.startCond();
    bits(4);
    xfer('{dev, 8'h02, 8'h8b}, 1'b1);
    expRoute[1] = 8'h8b;
    checkRoutes();
  endtask : tAbort

  // Foreign and read addresses are ignored; the strap moves the address.
  task automatic tAddr();
    xfer('{8'h86, 8'h01, 8'h9f}, 1'b0);
    xfer('{8'h07, 8'h01, 8'h9f}, 1'b0);
    @(posedge clk);
    addrStrap <= 1'b1;
    repeat (5) @(posedge clk);
    xfer('{8'h06, 8'h01, 8'h9f}, 1'b0);
    xfer('{8'h87, 8'h01, 8'h9f}, 1'b0);
    checkRoutes();
    xfer('{8'h86, 8'h01, 8'h9f}, 1'b1);
    expRoute[0] = 8'h9f;
    repeat (70) @(posedge clk);
    checkRoutes();
    check(16'(ampActive[0]), 16'h0001);
  endtask : tAddr

  // Reset, then the scenarios in order.
  initial begin
    repeat (20) @(posedge clk);
    sysRst <= 1'b0;
    repeat (10) @(posedge clk);
    tReset();
    tBurst();
    tClamp();
    tAbort();
    tAddr();
    end_sim();
  end
endmodule : testbench
